// ---- rtl/isc_regs.sv ----
/*
 * Control and configuration register bank of an image sensor: word port
 * behind the two-wire serial front end, frame-synchronised window and
 * exposure settings, standby gating, restart and trigger, pixel clock
 * shaping and the synthesiser controls.
 * Assumes a serial front end that delivers whole 16-bit words with an
 * 8-bit address, and a readout sequencer that pulses at frame start.
 */
// Contract
// - Standby pin low or chip enable clear gates clocks, analog low power.
// - In standby reads are refused; only enable and polarity accept writes.
// - Continuous readout resumes at same point after standby, no corruption flag.
// - Entering standby disables the synthesiser; host re-enables it afterwards.
// - Identity is read-only: part code, analog and digital revision; mirrored.
// - First row is 11 bits, odd values use next lower even row.
// - First column rounds down to multiple of twice column bin factor.
// - Height and width minus one; even values use next higher odd.
// - Horizontal blank below mode minimum uses the minimum.
// - Vertical blank clamped to a minimum of eight rows.
// - Window, blanking and exposure writes apply at next frame boundary.
// - Hold bit defers updates; frame-synchronised fields still wait a boundary.
// - Chip enable clear stops readout; writing it leaves other registers alone; clearing it here also clears synthesiser power and select.
// - Exposure rows are upper times 65536 plus lower; lower zero means one.
// - Clock polarity bit inverts the pixel output clock.
// - Signed clock shift delays the pixel clock, only when divided.
// - Divide field divides pixel clock by twice its value; zero undivided.
// - Software trigger acts as one trigger only in snapshot mode.
// - With pause set, restart stays set and readout waits at row 0.
// - Restart abandons the frame and self-clears unless pause is set.
// - Soft reset restores defaults except enable, hold, itself, synthesiser.
module isc_regs
  import isc_pkg::*;
#(
  parameter logic [7:0] PART_CODE = 8'h5c,  // Arbitrary value.
  parameter logic [3:0] ANA_REV   = 4'h1,   // Arbitrary value.
  parameter logic [3:0] DIG_REV   = 4'h1    // Arbitrary value.
)(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  // Word port from the serial front end
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic [7:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  output logic      [15:0] o_rdata_q,
  output logic             o_rack_q,
  output logic             o_rrefuse_q,
  // Pins and sequencer status
  input  wire logic        i_standby_n,
  input  wire logic        i_frame_start,
  input  wire logic [11:0] i_hblank_min,
  // Effective configuration
  output isc_frame_t       o_frame_q,
  output isc_mode_t        o_mode_q,
  output isc_synth_t       o_synth,
  output isc_seq_t         o_seq_q,
  // Power and run state
  output logic             o_run_q,
  output logic             o_clk_en_q,
  output logic             o_analog_lp_q,
  output logic             o_halt_q,
  // Pixel output clock
  output logic             o_pix_clk_q,
  output logic             o_pix_bypass_q,
  output logic             o_pix_en_q
);

  // Offset and reset value of every stored word, in slot order.
  localparam logic [23:0] TAB [`ISC_NSLOT] = '{
    `ISC_E_ROW,
    `ISC_E_COL,
    `ISC_E_HGT,
    `ISC_E_WID,
    `ISC_E_HBL,
    `ISC_E_VBL,
    `ISC_E_CTL,
    `ISC_E_EXH,
    `ISC_E_EXL,
    `ISC_E_PCK,
    `ISC_E_TRM,
    `ISC_E_PLC,
    `ISC_E_PL1,
    `ISC_E_PL2,
    `ISC_E_RM1,
    `ISC_E_RM2,
    `ISC_E_RDEC,
    `ISC_E_CDEC,
    `ISC_E_GGA,
    `ISC_E_GBL,
    `ISC_E_GRD,
    `ISC_E_GGB,
    `ISC_E_GALL,
    `ISC_E_BTGT,
    `ISC_E_BOFS,
    `ISC_E_BSMP,
    `ISC_E_BTA,
    `ISC_E_BDL,
    `ISC_E_BTB,
    `ISC_E_BTL,
    `ISC_E_OGA,
    `ISC_E_OGB,
    `ISC_E_BCC,
    `ISC_E_ORD,
    `ISC_E_OBL
  };

  // Returns {hit, slot} for an address.
  function automatic logic [6:0] find_slot(input logic [7:0] a);
    logic [6:0] r;
    r = '0;
    for (int i = 0; i < `ISC_NSLOT; i++) begin
      if (TAB[i][`ISC_T_ADDR] == a) begin
        r = {1'b1, 6'(i)};
      end
    end
    return r;
  endfunction

  function automatic isc_bank_t rst_bank();
    isc_bank_t b;
    for (int i = 0; i < `ISC_NSLOT; i++) begin
      b[i] = TAB[i][`ISC_T_RST];
    end
    return b;
  endfunction

  // Bits that survive a soft reset.
  function automatic isc_word_t keep_mask(input logic [5:0] s);
    isc_word_t m;
    m = '0;
    if (s == `ISC_S_CTL) begin
      m[`ISC_B_HOLD] = 1'b1;
      m[`ISC_B_CE]   = 1'b1;
    end
    if (s == `ISC_S_PLC) begin
      m[`ISC_B_PPWR] = 1'b1;
      m[`ISC_B_PSEL] = 1'b1;
    end
    if (s == `ISC_S_PL1) begin
      m[`ISC_F_PLLM] = '1;
      m[`ISC_F_PLLN] = '1;
    end
    if (s == `ISC_S_PL2) begin
      m[`ISC_F_PLLP] = '1;
    end
    return m;
  endfunction

  // Turns programmed words into the values the sequencer uses.
  function automatic isc_frame_t eff(input isc_bank_t b, input logic [11:0] hmin);
    isc_frame_t f;
    logic [1:0]  bin;
    logic [2:0]  cmask;
    logic [10:0] vbl;
    logic [11:0] hbl;
    logic [15:0] lo;
    bin   = b[`ISC_S_CDEC][`ISC_F_CBIN];
    cmask = {bin[1], |bin, 1'b1};
    vbl   = b[`ISC_S_VBL][`ISC_F_VBL];
    hbl   = b[`ISC_S_HBL][`ISC_F_HBL];
    lo    = b[`ISC_S_EXL];
    f.first_row = b[`ISC_S_ROW][`ISC_F_ROW] & ~11'h001;
    f.first_col = b[`ISC_S_COL][`ISC_F_COL] & ~{9'h000, cmask};
    f.height_m1 = b[`ISC_S_HGT][`ISC_F_VBL] | 11'h001;
    f.width_m1  = b[`ISC_S_WID][`ISC_F_COL] | 12'h001;
    f.hblank    = (hbl < hmin) ? hmin : hbl;
    f.vblank    = (vbl < `ISC_VBL_MIN) ? `ISC_VBL_MIN : vbl;
    f.expo_rows = {b[`ISC_S_EXH][`ISC_F_EXH], (lo == 16'h0000) ? 16'h0001 : lo};
    f.trim      = b[`ISC_S_TRM][`ISC_F_TRM];
    return f;
  endfunction

  function automatic isc_mode_t modes(input isc_bank_t b);
    return '{b[`ISC_S_RM1], b[`ISC_S_RM2], b[`ISC_S_RDEC], b[`ISC_S_CDEC]};
  endfunction

  localparam isc_bank_t RST_BANK = rst_bank();

  isc_bank_t  bank_q;
  isc_bank_t  bank_d;
  logic       soft_q;
  logic       restart_q;
  logic       pause_q;
  logic       sby_q;
  logic [7:0] cnt_q;

  // Address decode.
  wire logic [6:0] slot      = find_slot(i_addr);
  wire logic       slot_hit  = slot[6];
  wire logic [5:0] slot_idx  = slot[5:0];
  wire logic       is_ident  = (i_addr == `ISC_A_IDENT) || (i_addr == `ISC_A_IDENT_ALT);
  wire logic       is_rstrt  = (i_addr == `ISC_A_RESTART);
  wire logic       is_soft   = (i_addr == `ISC_A_SOFTRST);
  wire logic       is_ctl    = slot_hit && (slot_idx == `ISC_S_CTL);

  // Standby state.
  wire isc_word_t  ctl       = bank_q[`ISC_S_CTL];
  wire logic       ce        = ctl[`ISC_B_CE];
  wire logic       hold      = ctl[`ISC_B_HOLD];
  wire logic       sby_pin   = ~(i_standby_n ^ ctl[`ISC_B_SBYINV]);
  wire logic       sby       = sby_pin | ~ce;
  // Only the entry edge clears the synthesiser, so the host can power it later.
  wire logic       sby_enter = sby & ~sby_q;

  // Write qualification; standby leaves only the control word open.
  wire logic       wr_slot   = i_wr && slot_hit && !soft_q && (!sby || is_ctl);
  wire logic       wr_rstrt  = i_wr && is_rstrt && !sby && !soft_q;
  wire logic       wr_soft   = i_wr && is_soft && !sby;
  wire isc_word_t  sby_mask  = isc_word_t'((16'h0001 << `ISC_B_CE) | (16'h0001 << `ISC_B_SBYINV));

  always_comb begin
    bank_d = bank_q;
    // The reload repeats while the bit is set, so no racing write can stick.
    if (soft_q) begin
      for (int i = 0; i < `ISC_NSLOT; i++) begin
        bank_d[i] = (RST_BANK[i] & ~keep_mask(6'(i))) | (bank_q[i] & keep_mask(6'(i)));
      end
    end else if (wr_slot) begin
      // Only the addressed word changes; an enable clear still drops synthesiser power and select on standby entry.
      if (sby) begin
        bank_d[slot_idx] = (bank_q[slot_idx] & ~sby_mask) | (i_wdata & sby_mask);
      end else begin
        bank_d[slot_idx] = i_wdata;
      end
    end
    if (sby_enter) begin
      bank_d[`ISC_S_PLC][`ISC_B_PPWR] = 1'b0;
      bank_d[`ISC_S_PLC][`ISC_B_PSEL] = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      bank_q <= RST_BANK;
    end else begin
      bank_q <= bank_d;
    end
  end

  // Soft reset bit and standby tracking.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      soft_q <= 1'b0;
      sby_q  <= 1'b0;
    end else begin
      sby_q <= sby;
      if (wr_soft) begin
        soft_q <= i_wdata[`ISC_B_SOFT];
      end
    end
  end

  // Frame-synchronised copies; hold defers them until it is cleared.
  wire logic apply = i_frame_start && !hold && !sby;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_frame_q <= eff(RST_BANK, 12'h000);
      o_mode_q  <= modes(RST_BANK);
    end else if (soft_q || apply) begin
      o_frame_q <= eff(bank_q, i_hblank_min);
      o_mode_q  <= modes(bank_q);
    end
  end

  // Restart, pause and software trigger.
  wire logic snapshot = bank_q[`ISC_S_RM1][`ISC_B_SNAP];
  wire logic trig_hit = wr_rstrt && i_wdata[`ISC_B_TRIG] && snapshot;

  always_ff @(posedge i_clk) begin
    if (i_srst || soft_q) begin
      restart_q <= 1'b0;
      pause_q   <= 1'b0;
      o_seq_q   <= '0;
    end else begin
      o_seq_q.restart    <= wr_rstrt && i_wdata[`ISC_B_RESTART];
      o_seq_q.sw_trigger <= trig_hit;
      o_seq_q.pause_row0 <= restart_q && pause_q;
      if (wr_rstrt) begin
        pause_q   <= i_wdata[`ISC_B_PAUSE];
        restart_q <= i_wdata[`ISC_B_RESTART] && i_wdata[`ISC_B_PAUSE];
      end else if (!pause_q) begin
        restart_q <= 1'b0;
      end
    end
  end

  // Read path.
  // A refused read leaves the last word; only an acknowledge vouches for it.
  wire isc_word_t ident  = {PART_CODE, ANA_REV, DIG_REV};
  wire isc_word_t rs_val = isc_word_t'({pause_q, restart_q}); 
  wire isc_word_t rd_mux = is_ident ? ident :
                           is_rstrt ? rs_val :
                           is_soft  ? isc_word_t'(soft_q) :
                           slot_hit ? bank_q[slot_idx] : 16'h0000;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_rdata_q   <= 16'h0000;
      o_rack_q    <= 1'b0;
      o_rrefuse_q <= 1'b0;
    end else begin
      o_rack_q    <= i_rd && !sby;
      o_rrefuse_q <= i_rd && sby;
      if (i_rd && !sby) begin
        o_rdata_q <= rd_mux;
      end
    end
  end

  // Run state; the sequencer keeps its position, so standby just freezes it.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_run_q       <= 1'b0;
      o_clk_en_q    <= 1'b0;
      o_analog_lp_q <= 1'b1;
      o_halt_q      <= 1'b0;
    end else begin
      o_run_q       <= !sby && !soft_q && !(restart_q && pause_q);
      o_clk_en_q    <= !sby;
      o_analog_lp_q <= sby;
      o_halt_q      <= soft_q;
    end
  end

  assign o_synth = '{bank_q[`ISC_S_PLC][`ISC_B_PPWR], bank_q[`ISC_S_PLC][`ISC_B_PSEL],
                     bank_q[`ISC_S_PL1][`ISC_F_PLLM], bank_q[`ISC_S_PL1][`ISC_F_PLLN],
                     bank_q[`ISC_S_PL2][`ISC_F_PLLP]};

  // Pixel clock divider: period is twice the divide value.
  wire isc_word_t  pck      = bank_q[`ISC_S_PCK];
  wire logic [6:0] pc_div   = pck[`ISC_F_DIV];
  wire logic       pc_inv   = pck[`ISC_B_PINV];
  wire logic       bypass   = (pc_div == 7'h00);
  wire logic [7:0] pc_per   = {pc_div, 1'b0};
  wire logic       pc_wrap  = (cnt_q >= (pc_per - 8'h01));
  wire logic [8:0] pc_sh    = {{6{pck[`ISC_B_SHSIGN]}}, pck[`ISC_F_SHIFT]};
  wire logic [8:0] ph_raw   = {1'b0, cnt_q} - pc_sh;
  wire logic [8:0] ph_up    = ph_raw + {1'b0, pc_per};
  wire logic [8:0] ph_dn    = ph_raw - {1'b0, pc_per};
  // Folding into one period lets a positive shift wrap instead of underflow.
  wire logic [8:0] phase    = ph_raw[8] ? ph_up : ((ph_raw >= {1'b0, pc_per}) ? ph_dn : ph_raw);
  wire logic       pc_level = (phase < {2'b00, pc_div});

  always_ff @(posedge i_clk) begin
    if (i_srst || sby || bypass || pc_wrap) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_pix_clk_q    <= 1'b0;
      o_pix_bypass_q <= 1'b1;
      o_pix_en_q     <= 1'b0;
    end else begin
      o_pix_bypass_q <= bypass;
      o_pix_en_q     <= !sby && (bypass || pc_wrap);
      if (bypass || sby) begin
        o_pix_clk_q <= pc_inv;
      end else begin
        o_pix_clk_q <= pc_level ^ pc_inv;
      end
    end
  end

endmodule

// ---- rtl/isc_map.svh ----
/*
 * Register map of the image sensor control bank: offsets, reset values,
 * slot indices, field positions and fixed limits.
 * Assumes inclusion by the package and by the control bank module.
 */
`ifndef ISC_MAP_SVH
`define ISC_MAP_SVH

// Bank table entries: {offset, reset value}.
`define ISC_E_ROW   {8'h01, 16'h0036}
`define ISC_E_COL   {8'h02, 16'h0010}
`define ISC_E_HGT   {8'h03, 16'h0797}
`define ISC_E_WID   {8'h04, 16'h0a1f}
`define ISC_E_HBL   {8'h05, 16'h0000}
`define ISC_E_VBL   {8'h06, 16'h0019}
`define ISC_E_CTL   {8'h07, 16'h1f82}
`define ISC_E_EXH   {8'h08, 16'h0000}
`define ISC_E_EXL   {8'h09, 16'h0797}
`define ISC_E_PCK   {8'h0a, 16'h0000}
`define ISC_E_TRM   {8'h0c, 16'h0000}
`define ISC_E_PLC   {8'h10, 16'h0050}
`define ISC_E_PL1   {8'h11, 16'h6404}
`define ISC_E_PL2   {8'h12, 16'h0000}
`define ISC_E_RM1   {8'h1e, 16'h4006}
`define ISC_E_RM2   {8'h20, 16'h0040}
`define ISC_E_RDEC  {8'h22, 16'h0000}
`define ISC_E_CDEC  {8'h23, 16'h0000}
`define ISC_E_GGA   {8'h2b, 16'h0008}
`define ISC_E_GBL   {8'h2c, 16'h0008}
`define ISC_E_GRD   {8'h2d, 16'h0008}
`define ISC_E_GGB   {8'h2e, 16'h0008}
`define ISC_E_GALL  {8'h35, 16'h0008}
`define ISC_E_BTGT  {8'h49, 16'h00a8}
`define ISC_E_BOFS  {8'h4b, 16'h0028}
`define ISC_E_BSMP  {8'h5b, 16'h0001}
`define ISC_E_BTA   {8'h5c, 16'h005a}
`define ISC_E_BDL   {8'h5d, 16'h2d13}
`define ISC_E_BTB   {8'h5e, 16'h41ff}
`define ISC_E_BTL   {8'h5f, 16'h231d}
`define ISC_E_OGA   {8'h60, 16'h0020}
`define ISC_E_OGB   {8'h61, 16'h0020}
`define ISC_E_BCC   {8'h62, 16'h0000}
`define ISC_E_ORD   {8'h63, 16'h0020}
`define ISC_E_OBL   {8'h64, 16'h0020}
`define ISC_NSLOT   35
`define ISC_T_ADDR  23:16
`define ISC_T_RST   15:0

// Registers outside the bank table.
`define ISC_A_IDENT     8'h00
`define ISC_A_IDENT_ALT 8'hff
`define ISC_A_RESTART   8'h0b
`define ISC_A_SOFTRST   8'h0d

// Slot indices of the bank table.
`define ISC_S_ROW  6'h00
`define ISC_S_COL  6'h01
`define ISC_S_HGT  6'h02
`define ISC_S_WID  6'h03
`define ISC_S_HBL  6'h04
`define ISC_S_VBL  6'h05
`define ISC_S_CTL  6'h06
`define ISC_S_EXH  6'h07
`define ISC_S_EXL  6'h08
`define ISC_S_PCK  6'h09
`define ISC_S_TRM  6'h0a
`define ISC_S_PLC  6'h0b
`define ISC_S_PL1  6'h0c
`define ISC_S_PL2  6'h0d
`define ISC_S_RM1  6'h0e
`define ISC_S_RM2  6'h0f
`define ISC_S_RDEC 6'h10
`define ISC_S_CDEC 6'h11

// Single-bit fields.
`define ISC_B_HOLD    0
`define ISC_B_CE      1
`define ISC_B_SBYINV  2
`define ISC_B_RESTART 0
`define ISC_B_PAUSE   1
`define ISC_B_TRIG    2
`define ISC_B_SOFT    0
`define ISC_B_SNAP    8
`define ISC_B_PINV    15
`define ISC_B_PPWR    0
`define ISC_B_PSEL    1
`define ISC_B_SHSIGN  10

// Multi-bit fields.
`define ISC_F_ROW   10:0
`define ISC_F_COL   11:0
`define ISC_F_HBL   11:0
`define ISC_F_VBL   10:0
`define ISC_F_EXH   3:0
`define ISC_F_TRM   12:0
`define ISC_F_SHIFT 10:8
`define ISC_F_DIV   6:0
`define ISC_F_CBIN  5:4
`define ISC_F_PLLM  15:8
`define ISC_F_PLLN  5:0
`define ISC_F_PLLP  4:0

`define ISC_VBL_MIN 11'h008

`endif

// ---- rtl/isc_pkg.sv ----
/*
 * Types shared by the image sensor control bank and its users.
 * Assumes the register map header is on the include path.
 */
`include "isc_map.svh"

package isc_pkg;

  typedef logic [15:0] isc_word_t;
  typedef isc_word_t   isc_bank_t [`ISC_NSLOT];

  // Effective readout window, blanking and exposure.
  typedef struct packed {
    logic [10:0] first_row;
    logic [11:0] first_col;
    logic [10:0] height_m1;
    logic [11:0] width_m1;
    logic [11:0] hblank;
    logic [10:0] vblank;
    logic [19:0] expo_rows;
    logic [12:0] trim;
  } isc_frame_t;

  // Frame-synchronised readout mode words.
  typedef struct packed {
    isc_word_t mode_a;
    isc_word_t mode_b;
    isc_word_t row_dec;
    isc_word_t col_dec;
  } isc_mode_t;

  // Synthesiser controls.
  typedef struct packed {
    logic       power;
    logic       select;
    logic [7:0] mult;
    logic [5:0] prediv;
    logic [4:0] postdiv;
  } isc_synth_t;

  // Sequencer commands.
  typedef struct packed {
    logic restart;
    logic pause_row0;
    logic sw_trigger;
  } isc_seq_t;

endpackage

// ---- dv/isc_regs_checker.sv ----
/*
 * Port checker of the sensor control bank.
 * Assumes isc_pkg is compiled first; bound to every isc_regs instance.
 */
module isc_regs_checker
  import isc_pkg::*;
(
  // Clock, reset and word port
  input wire logic        i_clk,
  input wire logic        i_srst,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [7:0]  i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic [15:0] o_rdata_q,
  input wire logic        o_rack_q,
  input wire logic        o_rrefuse_q,
  // Pins and sequencer
  input wire logic        i_standby_n,
  input wire logic        i_frame_start,
  input wire logic [11:0] i_hblank_min,
  // Bank outputs
  input wire isc_frame_t  o_frame_q,
  input wire isc_mode_t   o_mode_q,
  input wire isc_synth_t  o_synth,
  input wire isc_seq_t    o_seq_q,
  input wire logic        o_run_q,
  input wire logic        o_clk_en_q,
  input wire logic        o_analog_lp_q,
  input wire logic        o_halt_q,
  input wire logic        o_pix_clk_q,
  input wire logic        o_pix_bypass_q,
  input wire logic        o_pix_en_q
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);

  rd_answer_a: assert property (i_rd |=> o_rack_q ^ o_rrefuse_q) else $error("read not answered once");
  no_stray_ack_a: assert property (!i_rd |=> !o_rack_q && !o_rrefuse_q) else $error("stray read answer");
  rdata_hold_a: assert property (!o_rack_q |-> $stable(o_rdata_q)) else $error("read word moved");
  frame_sync_a: assert property (!$past(i_frame_start) && !$past(o_halt_q) && !o_halt_q |-> $stable(o_frame_q))
    else $error("frame settings moved between boundaries");
  win_parity_a: assert property (!o_frame_q.first_row[0] && o_frame_q.height_m1[0] && o_frame_q.width_m1[0])
    else $error("window parity wrong");
  vblank_floor_a: assert property (o_frame_q.vblank >= 11'h008) else $error("vertical blank below floor");
  expo_floor_a: assert property (o_frame_q.expo_rows[15:0] != 16'h0000) else $error("exposure low part zero");
  trig_cause_a: assert property (o_seq_q.sw_trigger |-> $past(i_wr) && $past(i_addr) == 8'h0b && $past(i_wdata[2]))
    else $error("trigger without write");
  restart_cause_a: assert property ($rose(o_seq_q.restart) |-> $past(i_wr) && $past(i_addr) == 8'h0b)
    else $error("restart without write");
  pause_stops_a: assert property (o_seq_q.pause_row0 |-> !o_run_q) else $error("running while paused");
  sleep_state_a: assert property (!o_clk_en_q |-> !o_run_q && o_analog_lp_q && !o_pix_en_q)
    else $error("standby state incomplete");
  halt_stops_a: assert property (o_halt_q |-> !o_run_q) else $error("running in soft reset");
  div_pulse_a: assert property (!o_pix_bypass_q && o_pix_en_q ##1 !o_pix_bypass_q |-> !o_pix_en_q)
    else $error("divided enable too long");

  cover property (o_rrefuse_q);
  cover property (o_seq_q.sw_trigger);
  cover property (o_seq_q.pause_row0);
  cover property (o_halt_q ##1 !o_halt_q);
endmodule

bind isc_regs isc_regs_checker isc_regs_checker_inst (.*);

// ---- dv/isc_host.sv ----
/*
 * Host model on the word port: single-word writes and reads.
 * Assumes the bank takes strobes on the rising clock edge.
 */
module isc_host (
  // Clock and answers
  input  wire logic        i_clk,
  input  wire logic [15:0] o_rdata_q,
  input  wire logic        o_rack_q,
  input  wire logic        o_rrefuse_q,
  // Requests
  output logic             i_wr,
  output logic             i_rd,
  output logic [7:0]       i_addr,
  output logic [15:0]      i_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h5a;
    i_wdata = 16'ha5a5;
  end
  // Idle lines show the inverse so a stale value is never mistaken for a request.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge i_clk);
    i_addr = a;
    i_wdata = d;
    i_wr = 1'b1;
    @(negedge i_clk);
    i_wr = 1'b0;
    i_addr = ~a;
    i_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic k, output logic f);
    @(negedge i_clk);
    i_addr = a;
    i_rd = 1'b1;
    @(negedge i_clk);
    i_rd = 1'b0;
    i_addr = ~a;
    d = o_rdata_q;
    k = o_rack_q;
    f = o_rrefuse_q;
  endtask
  // The multiplier is kept in its legal span.
  function automatic logic [15:0] synth_word(input int m, input logic [5:0] n);
    return {8'(m < 16 ? 16 : m > 255 ? 255 : m), 2'b00, n};
  endfunction
endmodule

// ---- dv/isc_regs_tb_top.sv ----
/*
 * Self-checking bench of the sensor control bank with a register model.
 * Assumes isc_pkg, the checker and the host model are compiled first.
 */
module isc_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import isc_pkg::*;
  logic        i_clk, i_srst, i_standby_n, i_frame_start, i_wr, i_rd;
  logic        o_rack_q, o_rrefuse_q, o_run_q, o_clk_en_q, o_analog_lp_q, o_halt_q;
  logic        o_pix_clk_q, o_pix_bypass_q, o_pix_en_q;
  logic [11:0] i_hblank_min;
  logic [7:0]  i_addr;
  logic [15:0] i_wdata, o_rdata_q, lastd;
  isc_frame_t  o_frame_q, ef;
  isc_mode_t   o_mode_q, em;
  isc_synth_t  o_synth;
  isc_seq_t    o_seq_q;
  int          err_total, checks, n, hi;
  logic [15:0] mdl [logic [7:0]];
  logic [23:0] tbl [35] = '{24'h010036, 24'h020010, 24'h030797, 24'h040a1f, 24'h050000, 24'h060019,
    24'h071f82, 24'h080000, 24'h090797, 24'h0a0000, 24'h0c0000, 24'h100050, 24'h116404, 24'h120000,
    24'h1e4006, 24'h200040, 24'h220000, 24'h230000, 24'h2b0008, 24'h2c0008, 24'h2d0008, 24'h2e0008,
    24'h350008, 24'h4900a8, 24'h4b0028, 24'h5b0001, 24'h5c005a, 24'h5d2d13, 24'h5e41ff, 24'h5f231d,
    24'h600020, 24'h610020, 24'h620000, 24'h630020, 24'h640020};
  logic [23:0] fw [6] = '{24'h030100, 24'h040200, 24'h050001, 24'h060003, 24'h080005, 24'h090000};
  logic [47:0] pk [6] = '{48'h0000_0010_0000, 48'h8000_0010_0010, 48'h0001_0008_0008,
    48'h0002_0004_0008, 48'h0304_0002_0008, 48'h0008_0001_0008};
  logic [1:0]  cbs [3] = '{2'd0, 2'd1, 2'd3};

  // Identity parameters are arbitrary.
  isc_regs #(.PART_CODE(8'ha7), .ANA_REV(4'h3), .DIG_REV(4'h9)) isc_regs_inst (.*);
  isc_host isc_host_inst (.*);

  task automatic give_verdict();
    if (err_total == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] ex(input logic [7:0] a);
    return mdl.exists(a) ? mdl[a] : 16'h0000;
  endfunction
  function automatic logic sby();
    return !mdl[8'h07][1] || (i_standby_n == mdl[8'h07][2]);
  endfunction
  // Soft reset keeps enable, hold and the synthesiser fields.
  task automatic load(input logic keep);
    logic [7:0]  a;
    logic [15:0] m;
    foreach (tbl[i]) begin
      a = tbl[i][23:16];
      m = (a == 8'h07 || a == 8'h10) ? 16'h0003 : a == 8'h11 ? 16'hff3f : a == 8'h12 ? 16'h001f : 16'h0000;
      mdl[a] = (tbl[i][15:0] & ~(m & {16{keep}})) | (ex(a) & m & {16{keep}});
    end
    mdl[8'h0b] = 16'h0000;
  endtask
  task automatic w(input logic [7:0] a, input logic [15:0] d);
    isc_host_inst.wr(a, d);
    if (sby()) begin
      if (a == 8'h07) mdl[a] = (mdl[a] & 16'hfff9) | (d & 16'h0006);
    end else if (a == 8'h0d) begin
      mdl[a] = d & 16'h0001;
      if (d[0]) load(1'b1);
    end else if (!mdl[8'h0d][0] && a == 8'h0b) mdl[a] = d[1] ? d & 16'h0003 : 16'h0000;
    else if (!mdl[8'h0d][0] && mdl.exists(a) && a != 8'h00 && a != 8'hff) mdl[a] = d;
    if (sby()) mdl[8'h10] &= 16'hfffc;
  endtask
  task automatic rdc(input logic [7:0] a);
    logic [15:0] d;
    logic        k, f;
    isc_host_inst.rd(a, d, k, f);
    if (sby()) begin
      chk(f, 1'b1);
      chk(d, lastd);
    end else begin
      chk(k, 1'b1);
      chk(d, ex(a));
      lastd = ex(a);
    end
  endtask
  function automatic isc_frame_t eff();
    isc_frame_t e;
    logic [1:0] cb;
    cb = mdl[8'h23][5:4];
    e.first_row = mdl[8'h01][10:0] & 11'h7fe;
    e.first_col = mdl[8'h02][11:0] & ~(cb == 2'd0 ? 12'h001 : cb == 2'd1 ? 12'h003 : 12'h007);
    e.height_m1 = mdl[8'h03][10:0] | 11'h001;
    e.width_m1 = mdl[8'h04][11:0] | 12'h001;
    e.hblank = mdl[8'h05][11:0] < i_hblank_min ? i_hblank_min : mdl[8'h05][11:0];
    e.vblank = mdl[8'h06][10:0] < 11'h008 ? 11'h008 : mdl[8'h06][10:0];
    e.expo_rows = {mdl[8'h08][3:0], mdl[8'h09] == 16'h0000 ? 16'h0001 : mdl[8'h09]};
    e.trim = mdl[8'h0c][12:0];
    return e;
  endfunction
  task automatic fs();
    @(negedge i_clk);
    i_frame_start = 1'b1;
    @(negedge i_clk);
    i_frame_start = 1'b0;
    if (!mdl[8'h07][0] && !sby()) begin
      ef = eff();
      em = {mdl[8'h1e], mdl[8'h20], mdl[8'h22], mdl[8'h23]};
    end
    @(negedge i_clk);
    chk(o_frame_q, ef);
    chk(o_mode_q, em);
  endtask

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  initial begin
    repeat (50000) @(posedge i_clk);
    err_total++;
    give_verdict();
  end
  initial begin
    {i_srst, i_standby_n, i_frame_start, i_hblank_min} = {1'b1, 1'b1, 1'b0, 12'h000};
    {err_total, checks, lastd} = '0;
    n = $urandom(22621);
    {mdl[8'h00], mdl[8'hff], mdl[8'h0d]} = {16'ha739, 16'ha739, 16'h0000};
    load(1'b0);
    ef = eff();
    em = {mdl[8'h1e], mdl[8'h20], mdl[8'h22], mdl[8'h23]};
    repeat (2) @(negedge i_clk);
    i_srst = 1'b0;
    foreach (tbl[i]) rdc(tbl[i][23:16]);
    w(8'h00, 16'h1234);
    w(8'hff, 16'h1234);
    rdc(8'h00);
    rdc(8'hff);
    w(8'h40, 16'hbeef);
    rdc(8'h40);
    w(8'h11, isc_host_inst.synth_word($urandom % 300, 6'h04));
    rdc(8'h11);
    for (int a = 8'h2b; a <= 8'h2e; a++) begin
      w(8'(a), 16'($urandom));
      rdc(8'(a));
    end
    i_hblank_min = 12'($urandom);
    foreach (fw[i]) w(fw[i][23:16], fw[i][15:0]);
    w(8'h01, 16'(($urandom % 1002) * 2 + 1));
    w(8'h0c, 16'($urandom % 8192));
    chk(o_frame_q, ef);
    fs();
    w(8'h07, mdl[8'h07] | 16'h0001);
    w(8'h01, 16'h0010);
    fs();
    w(8'h07, mdl[8'h07] & 16'hfffe);
    chk(o_frame_q, ef);
    fs();
    foreach (cbs[i]) begin
      w(8'h23, {10'h000, cbs[i], 4'h0});
      w(8'h02, 16'(($urandom % 1376) * 2));
      fs();
    end
    w(8'h0b, 16'h0001);
    chk(o_seq_q.restart, 1'b1);
    rdc(8'h0b);
    w(8'h0b, 16'h0003);
    repeat (2) @(negedge i_clk);
    chk({o_seq_q.pause_row0, o_run_q}, 2'b10);
    rdc(8'h0b);
    w(8'h0b, 16'h0000);
    repeat (2) @(negedge i_clk);
    chk({o_seq_q.pause_row0, o_run_q}, 2'b01);
    w(8'h0b, 16'h0004);
    chk(o_seq_q.sw_trigger, 1'b0);
    w(8'h1e, mdl[8'h1e] | 16'h0100);
    fs();
    w(8'h0b, 16'h0004);
    chk(o_seq_q.sw_trigger, 1'b1);
    foreach (pk[i]) begin
      w(8'h0a, pk[i][47:32]);
      repeat (2) @(negedge i_clk);
      {n, hi} = '0;
      repeat (16) begin
        @(negedge i_clk);
        n += int'(o_pix_en_q);
        hi += int'(o_pix_clk_q);
      end
      chk(n, pk[i][31:16]);
      chk(hi, pk[i][15:0]);
      chk(o_pix_bypass_q, pk[i][38:32] == 7'h00);
    end
    w(8'h10, 16'h0053);
    w(8'h07, mdl[8'h07] & 16'hfffd);
    @(negedge i_clk);
    chk({o_clk_en_q, o_analog_lp_q, o_run_q}, 3'b010);
    rdc(8'h01);
    w(8'h01, 16'h0444);
    w(8'h07, mdl[8'h07] | 16'h0002);
    w(8'h0b, 16'h0001);
    rdc(8'h01);
    rdc(8'h10);
    chk(o_synth.power, 1'b0);
    w(8'h10, 16'h0053);
    i_standby_n = 1'b0;
    mdl[8'h10] &= 16'hfffc;
    repeat (2) @(negedge i_clk);
    chk(o_clk_en_q, 1'b0);
    rdc(8'h02);
    i_standby_n = 1'b1;
    rdc(8'h10);
    w(8'h07, mdl[8'h07] | 16'h0004);
    @(negedge i_clk);
    chk(o_clk_en_q, 1'b0);
    w(8'h07, mdl[8'h07] & 16'hfffb);
    w(8'h01, 16'h0022);
    w(8'h0d, 16'h0001);
    @(negedge i_clk);
    chk({o_halt_q, o_run_q}, 2'b10);
    w(8'h01, 16'h0444);
    foreach (tbl[i]) rdc(tbl[i][23:16]);
    w(8'h0d, 16'h0000);
    fs();
    chk(o_synth, {mdl[8'h10][0], mdl[8'h10][1], mdl[8'h11][15:8], mdl[8'h11][5:0], mdl[8'h12][4:0]});
    give_verdict();
  end
endmodule
